// ===== verilog/cscp_top.v
// Pin-side control logic of a single-cell charger: status pin, host
// alert pulse, charge gating, direct-path enable and button timing.
// Assumes one 25 MHz clock, internal charge-state inputs on that clock,
// and asynchronous pin inputs synchronised here.
//
// Implementation choices: the plain strobed port and the address map.
`include "cscp_consts.vh"
`timescale 1ns/1ns
`default_nettype none

module cscp_top
#(
   parameter [`CSCP_CNT_W-1:0] BLINK_HALF = `CSCP_BLINK_HALF,
   parameter [`CSCP_CNT_W-1:0] ALERT_CYC  = `CSCP_ALERT_CYC,
   parameter [`CSCP_CNT_W-1:0] SHIP_CYC   = `CSCP_SHIP_CYC,
   parameter [`CSCP_CNT_W-1:0] QRST_CYC   = `CSCP_QRST_CYC,
   parameter [`CSCP_CNT_W-1:0] BOFF_CYC   = `CSCP_BOFF_CYC
)
(
   input  wire                    core_clk,
   input  wire                    reset_n,
   // Register port
   input  wire [`CSCP_ADDR_W-1:0] reg_addr,
   input  wire [31:0]             reg_wdata,
   input  wire                    reg_wr,
   input  wire                    reg_rd,
   output reg  [31:0]             reg_rdata,
   output wire                    irq,
   // Internal charger state, core clock domain
   input  wire                    chg_active,
   input  wire                    chg_done,
   input  wire                    chg_sleep,
   input  wire                    chg_fault,
   input  wire                    chg_update,
   // Asynchronous pins and comparators
   input  wire                    charge_enable_n,
   input  wire                    battery_switch_button_n,
   input  wire                    thermistor_sense,
   input  wire                    vbus_present,
   // Open-drain pins
   output wire                    status_pin_o,
   output wire                    status_pin_oe,
   output wire                    host_alert_n_o,
   output wire                    host_alert_n_oe,
   // Control outputs
   output wire                    charge_enable,
   output wire                    direct_path_enable,
   output wire                    battery_path_switch,
   output wire [1:0]              dplus_level_sel,
   output wire [1:0]              dminus_level_sel
);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   reg  [11:0]             ctrl_reg;
   reg  [`CSCP_INT_W-1:0]  int_stat_reg;
   reg  [`CSCP_INT_W-1:0]  int_mask_reg;
   reg  [`CSCP_INT_W-1:0]  int_stat_next;
   reg                     ship_mode_reg;
   reg                     fault_seen_reg;
   reg                     therm_ok_d_reg;
   reg  [`CSCP_CNT_W-1:0]  blink_cnt_reg;
   reg                     blink_level_reg;
   reg  [`CSCP_CNT_W-1:0]  alert_cnt_reg;
   reg                     alert_on_reg;
   reg                     stat_drive_reg;
   reg                     stat_drive_next;
   reg  [31:0]             rdata_next;
   wire [3:0]              pins_sync;
   wire                    ce_n_s;
   wire                    button_n_s;
   wire                    therm_ok_s;
   wire                    vbus_s;
   wire                    fault_state;
   wire                    fault_rise;
   wire                    therm_leave;
   wire                    alert_event;
   wire                    ship_exit;
   wire                    sys_reset_start;
   wire                    switch_forced_off;
   wire [1:0]              stat_sel;
   wire                    wr_ctrl;
   wire                    wr_stat;
   wire                    wr_mask;

   // ----------------------------------------------------------------
   // Functions
   // ----------------------------------------------------------------
   function hit;
      input [`CSCP_ADDR_W-1:0] addr;
      input [`CSCP_ADDR_W-1:0] offset;
      begin
         hit = (addr == offset);
      end
   endfunction

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   cscp_sync
   #(
      .W       (4),
      .RST_VAL (4'h7)
   )
   u_sync
   (
      .core_clk (core_clk),
      .reset_n  (reset_n),
      .async_in ({vbus_present, thermistor_sense, battery_switch_button_n,
                  charge_enable_n}),
      .sync_out (pins_sync)
   );

   assign ce_n_s     = pins_sync[0];
   assign button_n_s = pins_sync[1];
   assign therm_ok_s = pins_sync[2];
   assign vbus_s     = pins_sync[3];

   // ----------------------------------------------------------------
   // Button timing
   // ----------------------------------------------------------------
   cscp_button
   #(
      .SHIP_CYC (SHIP_CYC),
      .QRST_CYC (QRST_CYC),
      .BOFF_CYC (BOFF_CYC)
   )
   u_button
   (
      .core_clk          (core_clk),
      .reset_n           (reset_n),
      .button_low        (~button_n_s),
      .vbus_present      (vbus_s),
      .ship_mode         (ship_mode_reg),
      .ship_exit         (ship_exit),
      .sys_reset_start   (sys_reset_start),
      .switch_forced_off (switch_forced_off)
   );

   // ----------------------------------------------------------------
   // Charge gating and control outputs
   // ----------------------------------------------------------------
   assign charge_enable = ctrl_reg[`CSCP_CTRL_ALLOW] & ~ce_n_s
                          & therm_ok_s;
   assign direct_path_enable  = ctrl_reg[`CSCP_CTRL_DIRECT_PATH_ENABLE];
   assign battery_path_switch = ~ship_mode_reg & ~switch_forced_off;
   assign dplus_level_sel     = ctrl_reg[`CSCP_CTRL_DP_LO+1:`CSCP_CTRL_DP_LO];
   assign dminus_level_sel    = ctrl_reg[`CSCP_CTRL_DM_LO+1:`CSCP_CTRL_DM_LO];
   assign stat_sel            = ctrl_reg[`CSCP_CTRL_STSEL_LO+1:`CSCP_CTRL_STSEL_LO];

   // ----------------------------------------------------------------
   // Ship mode
   // ----------------------------------------------------------------
   always @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
         ship_mode_reg <= 1'b0;
      else if (ship_exit)
         ship_mode_reg <= 1'b0;
      else if (wr_ctrl && reg_wdata[`CSCP_CTRL_SHIP])
         ship_mode_reg <= 1'b1;
   end

   // ----------------------------------------------------------------
   // Event detection
   // ----------------------------------------------------------------
   assign fault_state = chg_fault | ~therm_ok_s;
   assign fault_rise  = fault_state & ~fault_seen_reg;
   assign therm_leave = ~therm_ok_s & therm_ok_d_reg;
   assign alert_event = chg_update | fault_rise;

   always @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         fault_seen_reg <= 1'b0;
         therm_ok_d_reg <= 1'b1;
      end
      else
      begin
         fault_seen_reg <= fault_state;
         therm_ok_d_reg <= therm_ok_s;
      end
   end

   // ----------------------------------------------------------------
   // Status pin blink generator
   // ----------------------------------------------------------------
   always @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         blink_cnt_reg   <= {`CSCP_CNT_W{1'b0}};
         blink_level_reg <= 1'b0;
      end
      else if (!fault_state)
      begin
         blink_cnt_reg   <= {`CSCP_CNT_W{1'b0}};
         blink_level_reg <= 1'b0;
      end
      else if (blink_cnt_reg == BLINK_HALF - 1'b1)
      begin
         blink_cnt_reg   <= {`CSCP_CNT_W{1'b0}};
         blink_level_reg <= ~blink_level_reg;
      end
      else
         blink_cnt_reg <= blink_cnt_reg + 1'b1;
   end

   // ----------------------------------------------------------------
   // Status pin selection
   // ----------------------------------------------------------------
   always @*
   begin
      stat_drive_next = 1'b0;
      if (stat_sel != `CSCP_STSEL_ON)
         stat_drive_next = 1'b0;
      else if (fault_state)
         stat_drive_next = ~blink_level_reg;
      else if (chg_active && charge_enable)
         stat_drive_next = 1'b1;
      else if (chg_done || chg_sleep)
         stat_drive_next = 1'b0;
   end

   always @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
         stat_drive_reg <= 1'b0;
      else
         stat_drive_reg <= stat_drive_next;
   end

   assign status_pin_o  = 1'b0;
   assign status_pin_oe = stat_drive_reg;

   // ----------------------------------------------------------------
   // Host alert pulse, restarted by a new event
   // ----------------------------------------------------------------
   always @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         alert_cnt_reg <= {`CSCP_CNT_W{1'b0}};
         alert_on_reg  <= 1'b0;
      end
      else if (alert_event)
      begin
         alert_cnt_reg <= ALERT_CYC - 1'b1;
         alert_on_reg  <= 1'b1;
      end
      else if (alert_cnt_reg != {`CSCP_CNT_W{1'b0}})
         alert_cnt_reg <= alert_cnt_reg - 1'b1;
      else
         alert_on_reg <= 1'b0;
   end

   assign host_alert_n_o  = 1'b0;
   assign host_alert_n_oe = alert_on_reg;

   // ----------------------------------------------------------------
   // Register writes
   // ----------------------------------------------------------------
   assign wr_ctrl = reg_wr & hit(reg_addr, `CSCP_OFF_CTRL);
   assign wr_stat = reg_wr & hit(reg_addr, `CSCP_OFF_INT_STAT);
   assign wr_mask = reg_wr & hit(reg_addr, `CSCP_OFF_INT_MASK);

   always @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         ctrl_reg     <= `CSCP_CTRL_RST;
         int_mask_reg <= {`CSCP_INT_W{1'b0}};
      end
      else
      begin
         if (wr_ctrl)
            ctrl_reg <= {reg_wdata[11:4], 1'b0, 1'b0, reg_wdata[1:0]};
         if (wr_mask)
            int_mask_reg <= reg_wdata[`CSCP_INT_W-1:0];
      end
   end

   // ----------------------------------------------------------------
   // Interrupt status, set wins over write-one-to-clear
   // ----------------------------------------------------------------
   always @*
   begin
      int_stat_next = int_stat_reg;
      if (wr_stat)
         int_stat_next = int_stat_next & ~reg_wdata[`CSCP_INT_W-1:0];
      int_stat_next[`CSCP_INT_UPDATE] = int_stat_next[`CSCP_INT_UPDATE] | chg_update;
      int_stat_next[`CSCP_INT_FAULT]  = int_stat_next[`CSCP_INT_FAULT] | fault_rise;
      int_stat_next[`CSCP_INT_SHIPX]  = int_stat_next[`CSCP_INT_SHIPX] | ship_exit;
      int_stat_next[`CSCP_INT_SYSRST] = int_stat_next[`CSCP_INT_SYSRST] | sys_reset_start;
      int_stat_next[`CSCP_INT_THERM]  = int_stat_next[`CSCP_INT_THERM] | therm_leave;
   end

   always @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
         int_stat_reg <= {`CSCP_INT_W{1'b0}};
      else
         int_stat_reg <= int_stat_next;
   end

   assign irq = |(int_stat_reg & int_mask_reg);

   // ----------------------------------------------------------------
   // Register reads, data one cycle after the strobe
   // ----------------------------------------------------------------
   always @*
   begin
      rdata_next = 32'h0000_0000;
      if (reg_rd)
      begin
         case (reg_addr)
            `CSCP_OFF_CTRL:
               rdata_next = {20'h0_0000, ctrl_reg[11:3], ship_mode_reg,
                             ctrl_reg[1:0]};
            `CSCP_OFF_STATE:
               rdata_next = {24'h00_0000, vbus_s, ~button_n_s, therm_ok_s,
                             switch_forced_off, battery_path_switch,
                             stat_drive_reg, alert_on_reg, charge_enable};
            `CSCP_OFF_INT_STAT:
               rdata_next = {{(32-`CSCP_INT_W){1'b0}}, int_stat_reg};
            `CSCP_OFF_INT_MASK:
               rdata_next = {{(32-`CSCP_INT_W){1'b0}}, int_mask_reg};
            default:
               rdata_next = 32'h0000_0000;
         endcase
      end
   end

   always @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
         reg_rdata <= 32'h0000_0000;
      else
         reg_rdata <= rdata_next;
   end

endmodule

`default_nettype wire

// ===== pkg/cscp_consts.vh
// Constants for the charger status and control pin logic.
// Assumes a single 25 MHz core clock; included by bare name.
`ifndef CSCP_CONSTS_VH
`define CSCP_CONSTS_VH

// ----------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------
`define CSCP_CLK_HZ        25000000
`define CSCP_CNT_W         28
`define CSCP_BLINK_HZ      1
`define CSCP_BLINK_HALF    (`CSCP_CLK_HZ / (2 * `CSCP_BLINK_HZ))
`define CSCP_ALERT_US      256
`define CSCP_ALERT_CYC     ((`CSCP_CLK_HZ / 1000000) * `CSCP_ALERT_US)
`define CSCP_SHIP_S        1
`define CSCP_SHIP_CYC      (`CSCP_CLK_HZ * `CSCP_SHIP_S)
`define CSCP_QRST_S        10
`define CSCP_QRST_CYC      (`CSCP_CLK_HZ * `CSCP_QRST_S)
`define CSCP_BOFF_MS       320
`define CSCP_BOFF_CYC      ((`CSCP_CLK_HZ / 1000) * `CSCP_BOFF_MS)

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define CSCP_ADDR_W        8
`define CSCP_OFF_CTRL      8'h00
`define CSCP_OFF_STATE     8'h04
`define CSCP_OFF_INT_STAT  8'h08
`define CSCP_OFF_INT_MASK  8'h0c

// ----------------------------------------------------------------
// Control fields and reset values
// ----------------------------------------------------------------
`define CSCP_CTRL_ALLOW    0
`define CSCP_CTRL_DIRECT_PATH_ENABLE     1
`define CSCP_CTRL_SHIP     2
`define CSCP_CTRL_STSEL_LO 4
`define CSCP_CTRL_DP_LO    8
`define CSCP_CTRL_DM_LO    10
`define CSCP_CTRL_RST      12'h001
`define CSCP_STSEL_ON      2'h0

// ----------------------------------------------------------------
// Interrupt bits
// ----------------------------------------------------------------
`define CSCP_INT_W         5
`define CSCP_INT_UPDATE    0
`define CSCP_INT_FAULT     1
`define CSCP_INT_SHIPX     2
`define CSCP_INT_SYSRST    3
`define CSCP_INT_THERM     4

`endif

// ===== verilog/cscp_sync.v
// Two-stage synchroniser for asynchronous pin levels.
// Assumes a single core clock and an active-low asynchronous reset.
`timescale 1ns/1ns
`default_nettype none

module cscp_sync
#(
   parameter       W       = 4,
   parameter [W-1:0] RST_VAL = {W{1'b0}}
)
(
   input  wire         core_clk,
   input  wire         reset_n,
   input  wire [W-1:0] async_in,
   output reg  [W-1:0] sync_out
);

   reg [W-1:0] meta_reg;

   always @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         meta_reg <= RST_VAL;
         sync_out <= RST_VAL;
      end
      else
      begin
         meta_reg <= async_in;
         sync_out <= meta_reg;
      end
   end

endmodule

`default_nettype wire

// ===== verilog/cscp_button.v
// Push-button hold timer for ship-mode exit and system power reset.
// Assumes a synchronised active-high button-held level (button_low) on the core clock.
`include "cscp_consts.vh"
`timescale 1ns/1ns
`default_nettype none

module cscp_button
#(
   parameter [`CSCP_CNT_W-1:0] SHIP_CYC = `CSCP_SHIP_CYC,
   parameter [`CSCP_CNT_W-1:0] QRST_CYC = `CSCP_QRST_CYC,
   parameter [`CSCP_CNT_W-1:0] BOFF_CYC = `CSCP_BOFF_CYC
)
(
   input  wire core_clk,
   input  wire reset_n,
   input  wire button_low,
   input  wire vbus_present,
   input  wire ship_mode,
   output reg  ship_exit,
   output reg  sys_reset_start,
   output reg  switch_forced_off
);

   reg [`CSCP_CNT_W-1:0] hold_reg;
   reg [`CSCP_CNT_W-1:0] off_reg;

   // ----------------------------------------------------------------
   // Hold measurement, restarted when the button is released
   // ----------------------------------------------------------------
   always @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         hold_reg        <= {`CSCP_CNT_W{1'b0}};
         ship_exit       <= 1'b0;
         sys_reset_start <= 1'b0;
      end
      else
      begin
         ship_exit       <= 1'b0;
         sys_reset_start <= 1'b0;
         if (!button_low)
            hold_reg <= {`CSCP_CNT_W{1'b0}};
         else if (hold_reg != QRST_CYC)
         begin
            hold_reg <= hold_reg + 1'b1;
            if (hold_reg == SHIP_CYC - 1'b1 && ship_mode)
               ship_exit <= 1'b1;
            if (hold_reg == QRST_CYC - 1'b1 && !vbus_present && !ship_mode)
               sys_reset_start <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Battery switch off window for a full power reset
   // ----------------------------------------------------------------
   always @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         off_reg           <= {`CSCP_CNT_W{1'b0}};
         switch_forced_off <= 1'b0;
      end
      else if (sys_reset_start)
      begin
         off_reg           <= BOFF_CYC - 1'b1;
         switch_forced_off <= 1'b1;
      end
      else if (off_reg != {`CSCP_CNT_W{1'b0}})
         off_reg <= off_reg - 1'b1;
      else
         switch_forced_off <= 1'b0;
   end

endmodule

`default_nettype wire

// ===== sim/cscp_assertions.sv
// Concurrent checks on the pin-side outputs of the charger top.
// Assumes one clock domain; bound to every cscp_top instance.
`include "cscp_consts.vh"
`timescale 1ns/1ns
`default_nettype none
module cscp_assertions
#(
   parameter [`CSCP_CNT_W-1:0] ALERT_CYC = `CSCP_ALERT_CYC
)
(
   input wire logic                    core_clk,
   input wire logic                    reset_n,
   input wire logic [`CSCP_ADDR_W-1:0] reg_addr,
   input wire logic                    reg_wr,
   input wire logic                    chg_active,
   input wire logic                    chg_fault,
   input wire logic                    chg_update,
   input wire logic                    charge_enable_n,
   input wire logic                    thermistor_sense,
   input wire logic                    vbus_present,
   input wire logic                    status_pin_o,
   input wire logic                    status_pin_oe,
   input wire logic                    host_alert_n_o,
   input wire logic                    host_alert_n_oe,
   input wire logic                    charge_enable,
   input wire logic                    direct_path_enable,
   input wire logic                    battery_path_switch,
   input wire logic [1:0]              dplus_level_sel,
   input wire logic [1:0]              dminus_level_sel
);
   localparam [`CSCP_CNT_W-1:0] ONE = 1;
   logic                   upd_q;
   logic [`CSCP_CNT_W-1:0] al_run;
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!reset_n);
   // ---------------------------------------------
   // Length of the current alert pulse
   // ---------------------------------------------
   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         upd_q  <= 1'b0;
         al_run <= '0;
      end
      else
      begin
         upd_q <= chg_update;
         if (!host_alert_n_oe)
            al_run <= '0;
         else if (upd_q)
            al_run <= ONE;
         else
            al_run <= al_run + ONE;
      end
   end
   sequence s_blink_on;
      status_pin_oe [*8] ##1 !status_pin_oe;
   endsequence
   sequence s_reset_off;
      !battery_path_switch [*5] ##1 !battery_path_switch [*5] ##1 battery_path_switch;
   endsequence
   // ---------------------------------------------
   // Checks
   // ---------------------------------------------
   a_od_zero: assert property (!status_pin_o && !host_alert_n_o)
      else $error("open-drain data driven high");
   a_stat_release: assert property
      ((!chg_active && !chg_fault && thermistor_sense) [*3] |=> !status_pin_oe)
      else $error("status pin held low when idle");
   a_blink_half: assert property ((chg_fault && $rose(status_pin_oe)) |-> s_blink_on)
      else $error("blink half period wrong");
   a_alert_rise: assert property (chg_update |=> host_alert_n_oe)
      else $error("alert not started");
   a_alert_width: assert property ($fell(host_alert_n_oe) |-> al_run == ALERT_CYC)
      else $error("alert width wrong");
   a_charge_gate: assert property (charge_enable |-> !$past(charge_enable_n, 2))
      else $error("charging without enable pin");
   a_direct_path_enable_write: assert property
      ($changed(direct_path_enable) |-> $past(reg_wr) && $past(reg_addr) == `CSCP_OFF_CTRL)
      else $error("direct path changed without write");
   a_reset_off: assert property (($fell(battery_path_switch) && !vbus_present) |-> s_reset_off)
      else $error("power reset off time wrong");
   a_level_write: assert property
      ($changed({dplus_level_sel, dminus_level_sel})
       |-> $past(reg_wr) && $past(reg_addr) == `CSCP_OFF_CTRL)
      else $error("level select changed without write");
endmodule
bind cscp_top cscp_assertions #(.ALERT_CYC(ALERT_CYC)) u_cscp_assertions (.*);
`default_nettype wire

// ===== sim/cscp_partner.sv
// Far side model: push button and pull-ups on the open-drain pins.
// Assumes the testbench presses the button through the press task.
`timescale 1ns/1ns
`default_nettype none
module cscp_partner
(
   input  wire logic core_clk,
   input  wire logic status_pin_o,
   input  wire logic status_pin_oe,
   input  wire logic host_alert_n_o,
   input  wire logic host_alert_n_oe,
   output var  logic battery_switch_button_n,
   output wire logic stat_level,
   output wire logic alert_level
);
   // Pull-ups give a high level when released
   assign stat_level  = status_pin_oe ? status_pin_o : 1'b1;
   assign alert_level = host_alert_n_oe ? host_alert_n_o : 1'b1;
   initial battery_switch_button_n = 1'b1;
   task automatic press(input int n);
      @(posedge core_clk);
      battery_switch_button_n <= 1'b0;
      repeat (n) @(posedge core_clk);
      battery_switch_button_n <= 1'b1;
   endtask
endmodule
`default_nettype wire

// ===== sim/cscp_top_tb.sv
// Self-checking bench for the charger pin-side logic.
// Assumes short timer parameters and the register port of cscp_top.
`include "cscp_consts.vh"
`timescale 1ns/1ns
`default_nettype none
module cscp_top_tb;
   localparam int BLINK = 8, ALERT = 16, SHIP = 20, QRST = 60, BOFF = 10;
   logic        core_clk, reset_n, reg_wr, reg_rd;
   logic [7:0]  reg_addr;
   logic [31:0] reg_wdata;
   logic        chg_active, chg_done, chg_sleep, chg_fault, chg_update;
   logic        charge_enable_n, thermistor_sense, vbus_present;
   wire  [31:0] reg_rdata;
   wire         irq, status_pin_o, status_pin_oe, host_alert_n_o, host_alert_n_oe;
   wire         charge_enable, direct_path_enable, battery_path_switch;
   wire  [1:0]  dplus_level_sel, dminus_level_sel;
   wire         button_n, stat_level, alert_level;
   int          fail_count = 0;
   int          samples_checked = 0;
   cscp_top #(.BLINK_HALF(BLINK), .ALERT_CYC(ALERT), .SHIP_CYC(SHIP),
      .QRST_CYC(QRST), .BOFF_CYC(BOFF)) u_cscp_top
      (.battery_switch_button_n(button_n), .*);
   cscp_partner u_cscp_partner (.core_clk(core_clk), .status_pin_o(status_pin_o),
      .status_pin_oe(status_pin_oe), .host_alert_n_o(host_alert_n_o),
      .host_alert_n_oe(host_alert_n_oe), .battery_switch_button_n(button_n),
      .stat_level(stat_level), .alert_level(alert_level));
   // ---------------------------------------------
   // Bus, timing and compare tasks
   // ---------------------------------------------
   task automatic end_sim;
      if (fail_count == 0 && samples_checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk32(input logic [31:0] g, input logic [31:0] e);
      samples_checked++;
      if (g !== e)
      begin
         fail_count++;
         $display("[ERR] %0t got %h expected %h", $time, g, e);
      end
   endtask
   task automatic chk1(input logic g, input logic e);
      chk32({31'h0, g}, {31'h0, e});
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1;
      chk32(reg_rdata, e);
   endtask
   function automatic logic lv(input int w);
      return w == 0 ? stat_level : w == 1 ? alert_level : w == 2 ? battery_path_switch
         : !stat_level;
   endfunction
   // Waits for a low level, then counts its cycles
   task automatic low_len(input int w, output int n);
      n = 0;
      for (int i = 0; i < 300 && lv(w) !== 1'b0; i++) wt(1);
      while (lv(w) === 1'b0 && n < 300)
      begin
         wt(1);
         n++;
      end
   endtask
   task automatic pulse;
      @(posedge core_clk);
      chg_update <= 1'b1;
      wt(1);
      chg_update <= 1'b0;
   endtask
   task automatic upd(input int gap, output int n);
      pulse();
      if (gap > 0)
      begin
         wt(gap);
         pulse();
      end
      low_len(1, n);
   endtask
   initial
   begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end
   initial
   begin
      #(40 * 20000);
      fail_count++;
      end_sim();
   end
   // ---------------------------------------------
   // Scenarios
   // ---------------------------------------------
   initial
   begin
      int n;
      {reset_n, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
      {chg_active, chg_done, chg_sleep, chg_fault, chg_update, vbus_present} = '0;
      {charge_enable_n, thermistor_sense} = 2'h3;
      wt(3);
      reset_n <= 1'b1;
      wt(3);
      rd_chk(`CSCP_OFF_CTRL, 32'h001);
      rd_chk(`CSCP_OFF_STATE, 32'h28);
      rd_chk(`CSCP_OFF_INT_MASK, 32'h0);
      wr(8'h10, 32'hfff);
      rd_chk(8'h10, 32'h0);
      rd_chk(`CSCP_OFF_CTRL, 32'h001);
      charge_enable_n <= 1'b0;
      wt(3);
      chk1(charge_enable, 1'b1);
      wr(`CSCP_OFF_CTRL, 32'h0);
      wt(1);
      chk1(charge_enable, 1'b0);
      wr(`CSCP_OFF_CTRL, 32'h1);
      chg_active <= 1'b1;
      wt(2);
      chk1(stat_level, 1'b0);
      for (int i = 1; i < 4; i++)
      begin
         wr(`CSCP_OFF_CTRL, 32'h1 | (i << 4));
         wt(2);
         chk1(stat_level, 1'b1);
      end
      wr(`CSCP_OFF_CTRL, 32'h1);
      {chg_active, chg_done} <= 2'h1;
      wt(2);
      chk1(stat_level, 1'b1);
      {chg_done, chg_sleep} <= 2'h1;
      wt(2);
      chk1(stat_level, 1'b1);
      chg_sleep <= 1'b0;
      wr(`CSCP_OFF_INT_STAT, 32'h1f);
      wr(`CSCP_OFF_INT_MASK, 32'h1);
      upd(0, n);
      chk32(n, ALERT);
      chk1(irq, 1'b1);
      rd_chk(`CSCP_OFF_INT_STAT, 32'h1);
      wr(`CSCP_OFF_INT_STAT, 32'h1);
      wt(1);
      chk1(irq, 1'b0);
      wr(`CSCP_OFF_INT_MASK, 32'h0);
      upd(4, n);
      chk32(n, ALERT);
      chk1(irq, 1'b0);
      wr(`CSCP_OFF_INT_STAT, 32'h1f);
      chg_fault <= 1'b1;
      low_len(0, n);
      chk32(n, BLINK);
      low_len(3, n);
      chk32(n, BLINK);
      low_len(0, n);
      chg_fault <= 1'b0;
      rd_chk(`CSCP_OFF_INT_STAT, 32'h2);
      wt(20);
      wr(`CSCP_OFF_INT_STAT, 32'h1f);
      thermistor_sense <= 1'b0;
      wt(4);
      chk1(charge_enable, 1'b0);
      chk1(stat_level, 1'b0);
      rd_chk(`CSCP_OFF_INT_STAT, 32'h12);
      thermistor_sense <= 1'b1;
      wt(4);
      chk1(charge_enable, 1'b1);
      vbus_present <= 1'b1;
      wr(`CSCP_OFF_INT_STAT, 32'h1f);
      wr(`CSCP_OFF_CTRL, 32'h5);
      wt(1);
      chk1(battery_path_switch, 1'b0);
      rd_chk(`CSCP_OFF_CTRL, 32'h5);
      u_cscp_partner.press(SHIP - 5);
      wt(5);
      chk1(battery_path_switch, 1'b0);
      u_cscp_partner.press(SHIP + 5);
      wt(4);
      chk1(battery_path_switch, 1'b1);
      rd_chk(`CSCP_OFF_INT_STAT, 32'h4);
      rd_chk(`CSCP_OFF_CTRL, 32'h1);
      vbus_present <= 1'b0;
      u_cscp_partner.press(QRST - 10);
      wt(4);
      chk1(battery_path_switch, 1'b1);
      fork
         u_cscp_partner.press(QRST + 20);
         low_len(2, n);
      join
      chk32(n, BOFF);
      chk1(battery_path_switch, 1'b1);
      wr(`CSCP_OFF_CTRL, 32'h3);
      wt(1);
      chk1(direct_path_enable, 1'b1);
      for (int i = 0; i < 4; i++)
      begin
         wr(`CSCP_OFF_CTRL, 32'h1 | (i << 8) | ((3 - i) << 10));
         wt(1);
         chk32({28'h0, dminus_level_sel, dplus_level_sel}, ((3 - i) << 2) | i);
         chk1(direct_path_enable, 1'b0);
      end
      end_sim();
   end
endmodule
`default_nettype wire
